/* logic/mcu_core_params.svh */
// Constants for the instruction decode and execute block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MCU_CORE_PARAMS_SVH
`define MCU_CORE_PARAMS_SVH

`define INSTR_W        16
`define PC_W           13
`define FADDR_W        9
`define TPTR_W         12
`define DEST_BIT       7
`define BITNUM_LSB     7
`define OPC_BYTE_MSB   11
`define OPC_BYTE_LSB   8
`define LIT_MSB        7
`define PC_RESET       13'h0000
`define STACK_DEPTH    8

`endif

/* logic/mcu_core_pkg.sv */
// Types shared by the decode and execute block.
// Assumes mcu_core_params.svh is compiled alongside.
package mcu_core_pkg;

    typedef enum {
        opNop, opAddF, opSubF, opAndF, opOrF, opXorF, opClrF, opClrW,
        opComF, opDecF, opIncF, opDecSkip, opIncSkip, opMovF, opMovWF,
        opRlF, opRrF, opSwapF, opBitClr, opBitSet, opBtsc, opBtss,
        opAddL, opSubL, opAndL, opOrL, opXorL, opMovL, opCall, opJump,
        opRet, opRetI, opRetL, opWdtClr, opSleep, opTabH, opTabL
    } op_t;

    typedef enum {
        stExec, stFlush
    } state_t;

endpackage

/* logic/instr_classify.sv */
// Pure decoder from a 16-bit instruction word to an operation code.
// Assumes the word is stable while it is sampled.
`timescale 1ns/100ps
`include "mcu_core_params.svh"

module instr_classify (
    input  wire logic [`INSTR_W-1:0] instrWord, // Fetched word
    output mcu_core_pkg::op_t        opCode     // Decoded operation
);

    wire logic [3:0] byteOpc = instrWord[`OPC_BYTE_MSB:`OPC_BYTE_LSB];
    wire logic [1:0] topSel  = instrWord[13:12];
    wire logic       dBit    = instrWord[`DEST_BIT];

    always_comb
    begin
        opCode = mcu_core_pkg::opNop;
        if (topSel == 2'h2)
        begin
            opCode = instrWord[11] ? mcu_core_pkg::opJump : mcu_core_pkg::opCall;
        end
        else if (topSel == 2'h3)
        begin
            case (instrWord[11:10])
                2'h0:    opCode = mcu_core_pkg::opBitClr;
                2'h1:    opCode = mcu_core_pkg::opBitSet;
                2'h2:    opCode = mcu_core_pkg::opBtsc;
                default: opCode = mcu_core_pkg::opBtss;
            endcase
        end
        else if (instrWord[15:12] == 4'h1)
        begin
            case (byteOpc)
                4'h8:    opCode = mcu_core_pkg::opRetL;
                4'h9:    opCode = mcu_core_pkg::opMovL;
                4'hA:    opCode = mcu_core_pkg::opOrL;
                4'hB:    opCode = mcu_core_pkg::opAndL;
                4'hC:    opCode = mcu_core_pkg::opAddL;
                4'hD:    opCode = mcu_core_pkg::opXorL;
                4'hF:    opCode = mcu_core_pkg::opSubL;
                4'hE:
                begin
                    if (instrWord[7:0] == 8'h04)
                        opCode = mcu_core_pkg::opWdtClr;
                    else if (instrWord[7:0] == 8'h03)
                        opCode = mcu_core_pkg::opSleep;
                end
                default: opCode = mcu_core_pkg::opNop;
            endcase
        end
        else if (topSel == 2'h0)
        begin
            case (byteOpc)
                4'h0:
                begin
                    if (instrWord == 16'h0040)
                        opCode = mcu_core_pkg::opRet;
                    else if (instrWord == 16'h0060)
                        opCode = mcu_core_pkg::opRetI;
                    else if (instrWord == 16'h0058)
                        opCode = mcu_core_pkg::opTabH;
                    else if (instrWord == 16'h0050)
                        opCode = mcu_core_pkg::opTabL;
                    else if (dBit)
                        opCode = mcu_core_pkg::opMovWF;
                end
                4'h1:
                begin
                    if (dBit)
                        opCode = mcu_core_pkg::opClrF;
                    else if (instrWord == 16'h0140)
                        opCode = mcu_core_pkg::opClrW;
                end
                4'h2:    opCode = mcu_core_pkg::opSubF;
                4'h3:    opCode = mcu_core_pkg::opDecF;
                4'h4:    opCode = mcu_core_pkg::opOrF;
                4'h5:    opCode = mcu_core_pkg::opAndF;
                4'h6:    opCode = mcu_core_pkg::opXorF;
                4'h7:    opCode = mcu_core_pkg::opAddF;
                4'h8:    opCode = mcu_core_pkg::opMovF;
                4'h9:    opCode = mcu_core_pkg::opComF;
                4'hA:    opCode = mcu_core_pkg::opIncF;
                4'hB:    opCode = mcu_core_pkg::opDecSkip;
                4'hC:    opCode = mcu_core_pkg::opRrF;
                4'hD:    opCode = mcu_core_pkg::opRlF;
                4'hE:    opCode = mcu_core_pkg::opSwapF;
                default: opCode = mcu_core_pkg::opIncSkip;
            endcase
        end
    end

endmodule // instr_classify

/* logic/return_stack.sv */
// Small return-address stack with registered top.
// Assumes push and pop never occur in the same cycle.
`timescale 1ns/100ps
`include "mcu_core_params.svh"

module return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int WIDTH = `PC_W
) (
    input  wire logic             core_clk, // Core clock
    input  wire logic             reset,    // Synchronous reset, high
    input  wire logic             push,     // Push pushData
    input  wire logic             pop,      // Discard top
    input  wire logic [WIDTH-1:0] pushData, // Address to push
    output logic      [WIDTH-1:0] topData   // Current top
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_q;
    wire logic [$clog2(DEPTH)-1:0] ptrDown = ptr_q - 1'b1;
    wire logic [$clog2(DEPTH)-1:0] ptrUp   = ptr_q + 1'b1;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            ptr_q <= '0;
        else if (push)
            ptr_q <= ptrUp;
        else if (pop)
            ptr_q <= ptrDown;
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[ptr_q] <= pushData;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            topData <= '0;
        else if (push)
            topData <= pushData;
        else if (pop)
            topData <= mem_q[ptrDown - 1'b1];
    end

endmodule // return_stack

/* logic/mcu_instruction_decode_execute.sv */
// Decode and execute stage of the 8-bit accumulator core.
// Assumes a combinational file read port and program memory whose word
// for progAddr is valid in the same cycle; table reads use a second port.
`timescale 1ns/100ps
`include "mcu_core_params.svh"

module mcu_instruction_decode_execute (
    input  wire logic                core_clk,      // Core clock, 40 MHz
    input  wire logic                reset,         // Synchronous reset, high
    input  wire logic [`INSTR_W-1:0] instrWord,     // Word fetched at progAddr
    output logic      [`PC_W-1:0]    progAddr,      // Program counter
    output logic      [`TPTR_W-1:0]  tableAddr,     // Table read address
    input  wire logic [`INSTR_W-1:0] tableWord,     // Word at tableAddr
    input  wire logic [7:0]          tablePtrLow,   // Table pointer low byte
    input  wire logic [3:0]          tablePtrHigh,  // Table pointer high nibble
    output logic      [`FADDR_W-1:0] fileAddr,      // File address
    input  wire logic [7:0]          fileRdData,    // File read data
    output logic                     fileWrEn,      // File write strobe
    output logic      [7:0]          fileWrData,    // File write data
    output logic      [7:0]          workReg,       // Working register
    output logic                     carryFlag,     // Carry / not borrow
    output logic                     digit_carry_flag, // Digit carry
    output logic                     zeroFlag,      // Zero flag
    output logic                     gieSet,        // Set global interrupt enable
    output logic                     watchdogClear, // Clear watchdog counter
    output logic                     sleepReq,      // Enter power-down
    output logic                     time_out_flag, // Time-out status
    output logic                     power_down_flag // Power-down status
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    mcu_core_pkg::op_t    op;
    mcu_core_pkg::state_t state_q;
    mcu_core_pkg::state_t state_d;

    instr_classify uClassify (
        .instrWord (instrWord),
        .opCode    (op)
    );

    wire logic       flushNow = (state_q == mcu_core_pkg::stFlush);
    wire logic       dBit     = instrWord[`DEST_BIT];
    wire logic [2:0] bitNum   = instrWord[`BITNUM_LSB+2:`BITNUM_LSB];
    wire logic [7:0] literal  = instrWord[`LIT_MSB:0];
    wire logic [`PC_W-1:0] target = {instrWord[15:14], instrWord[10:0]};
    wire logic [`PC_W-1:0] pcNext = progAddr + 1'b1;
    wire logic [`PC_W-1:0] pcSkip = pcNext + 1'b1;
    wire logic [7:0] fVal     = fileRdData;
    wire logic [7:0] bitMask  = 8'h01 << bitNum;
    wire logic       testBit  = fVal[bitNum];

    assign fileAddr  = {instrWord[15:14], instrWord[6:0]};
    assign tableAddr = {tablePtrHigh, tablePtrLow};

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic

    wire logic       isLitOp = (op == mcu_core_pkg::opAddL) || (op == mcu_core_pkg::opSubL);
    wire logic [7:0] srcB    = isLitOp ? literal : fVal;
    wire logic [8:0] addSum  = {1'b0, workReg} + {1'b0, srcB};
    wire logic [4:0] addLow  = {1'b0, workReg[3:0]} + {1'b0, srcB[3:0]};
    wire logic [8:0] subDiff = {1'b0, srcB} - {1'b0, workReg};
    wire logic [4:0] subLow  = {1'b0, srcB[3:0]} - {1'b0, workReg[3:0]};
    wire logic [7:0] incVal  = fVal + 8'h01;
    wire logic [7:0] decVal  = fVal - 8'h01;

    logic [7:0] result;
    logic       toDest;
    logic       toWork;
    logic       setZ;
    logic       setC;
    logic       setDc;
    logic       newC;
    logic       newDc;
    logic       skip;
    logic       twoCycle;

    always_comb
    begin
        result   = 8'h00;
        toDest   = 1'b0;
        toWork   = 1'b0;
        setZ     = 1'b0;
        setC     = 1'b0;
        setDc    = 1'b0;
        newC     = carryFlag;
        newDc    = digit_carry_flag;
        skip     = 1'b0;
        twoCycle = 1'b0;
        case (op)
            mcu_core_pkg::opAddF, mcu_core_pkg::opAddL:
            begin
                result = addSum[7:0];
                newC   = addSum[8];
                newDc  = addLow[4];
                setC   = 1'b1;
                setDc  = 1'b1;
                setZ   = 1'b1;
                toDest = (op == mcu_core_pkg::opAddF);
                toWork = (op == mcu_core_pkg::opAddL);
            end
            mcu_core_pkg::opSubF, mcu_core_pkg::opSubL:
            begin
                result = subDiff[7:0];
                newC   = ~subDiff[8];
                newDc  = ~subLow[4];
                setC   = 1'b1;
                setDc  = 1'b1;
                setZ   = 1'b1;
                toDest = (op == mcu_core_pkg::opSubF);
                toWork = (op == mcu_core_pkg::opSubL);
            end
            mcu_core_pkg::opAndF:
            begin
                result = workReg & fVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opOrF:
            begin
                result = workReg | fVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opXorF:
            begin
                result = workReg ^ fVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opComF:
            begin
                result = ~fVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opDecF:
            begin
                result = decVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opIncF:
            begin
                result = incVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opClrF:
            begin
                result = 8'h00;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opClrW:
            begin
                result = 8'h00;
                setZ   = 1'b1;
                toWork = 1'b1;
            end
            mcu_core_pkg::opDecSkip, mcu_core_pkg::opIncSkip:
            begin
                result   = (op == mcu_core_pkg::opDecSkip) ? decVal : incVal;
                toDest   = 1'b1;
                skip     = (result == 8'h00);
                twoCycle = skip;
            end
            mcu_core_pkg::opMovF:
            begin
                result = fVal;
                setZ   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opMovWF:
            begin
                result = workReg;
                toDest = 1'b1;
            end
            mcu_core_pkg::opRlF:
            begin
                result = {fVal[6:0], carryFlag};
                newC   = fVal[7];
                setC   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opRrF:
            begin
                result = {carryFlag, fVal[7:1]};
                newC   = fVal[0];
                setC   = 1'b1;
                toDest = 1'b1;
            end
            mcu_core_pkg::opSwapF:
            begin
                result = {fVal[3:0], fVal[7:4]};
                toDest = 1'b1;
            end
            mcu_core_pkg::opBitClr:
            begin
                result = fVal & ~bitMask;
                toDest = 1'b1;
            end
            mcu_core_pkg::opBitSet:
            begin
                result = fVal | bitMask;
                toDest = 1'b1;
            end
            mcu_core_pkg::opBtsc, mcu_core_pkg::opBtss:
            begin
                skip     = (op == mcu_core_pkg::opBtss) ? testBit : ~testBit;
                twoCycle = skip;
            end
            mcu_core_pkg::opAndL:
            begin
                result = workReg & literal;
                setZ   = 1'b1;
                toWork = 1'b1;
            end
            mcu_core_pkg::opOrL:
            begin
                result = workReg | literal;
                setZ   = 1'b1;
                toWork = 1'b1;
            end
            mcu_core_pkg::opXorL:
            begin
                result = workReg ^ literal;
                setZ   = 1'b1;
                toWork = 1'b1;
            end
            mcu_core_pkg::opMovL, mcu_core_pkg::opRetL:
            begin
                result   = literal;
                toWork   = 1'b1;
                twoCycle = (op == mcu_core_pkg::opRetL);
            end
            mcu_core_pkg::opTabH, mcu_core_pkg::opTabL:
            begin
                result   = (op == mcu_core_pkg::opTabH) ? tableWord[15:8] : tableWord[7:0];
                toWork   = 1'b1;
                twoCycle = 1'b1;
            end
            mcu_core_pkg::opCall, mcu_core_pkg::opJump,
            mcu_core_pkg::opRet, mcu_core_pkg::opRetI:
                twoCycle = 1'b1;
            default:
                result = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Write targets and side effects

    wire logic live     = ~flushNow;
    wire logic wrFile   = live & toDest & dBit;
    wire logic wrWork   = live & (toWork | (toDest & ~dBit));
    wire logic isCall   = live & (op == mcu_core_pkg::opCall);
    wire logic isJump   = live & (op == mcu_core_pkg::opJump);
    wire logic isReturn = live & ((op == mcu_core_pkg::opRet) || (op == mcu_core_pkg::opRetI)
                                  || (op == mcu_core_pkg::opRetL));
    wire logic isWdt    = live & (op == mcu_core_pkg::opWdtClr);
    wire logic isSleep  = live & (op == mcu_core_pkg::opSleep);

    logic [`PC_W-1:0] stackTop;

    return_stack #(
        .DEPTH (`STACK_DEPTH),
        .WIDTH (`PC_W)
    ) uStack (
        .core_clk (core_clk),
        .reset    (reset),
        .push     (isCall),
        .pop      (isReturn),
        .pushData (pcNext),
        .topData  (stackTop)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program counter and sequencing

    logic [`PC_W-1:0] pc_d;

    always_comb
    begin
        pc_d = pcNext;
        // Dead cycle holds, so the word at the new address runs next
        if (flushNow)
            pc_d = progAddr;
        else if (isCall || isJump)
            pc_d = target;
        else if (isReturn)
            pc_d = stackTop;
        else if (skip)
            pc_d = pcSkip;
    end

    assign state_d = (live && twoCycle) ? mcu_core_pkg::stFlush : mcu_core_pkg::stExec;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            progAddr <= `PC_RESET;
            state_q  <= mcu_core_pkg::stExec;
        end
        else
        begin
            progAddr <= pc_d;
            state_q  <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural state

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            workReg          <= 8'h00;
            carryFlag        <= 1'b0;
            digit_carry_flag <= 1'b0;
            zeroFlag         <= 1'b0;
            fileWrEn         <= 1'b0;
            fileWrData       <= 8'h00;
        end
        else
        begin
            fileWrEn   <= wrFile;
            fileWrData <= result;
            if (wrWork)
                workReg <= result;
            if (live && setZ)
                zeroFlag <= (result == 8'h00);
            if (live && setC)
                carryFlag <= newC;
            if (live && setDc)
                digit_carry_flag <= newDc;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            gieSet          <= 1'b0;
            watchdogClear   <= 1'b0;
            sleepReq        <= 1'b0;
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b1;
        end
        else
        begin
            gieSet        <= live & (op == mcu_core_pkg::opRetI);
            watchdogClear <= isWdt;
            sleepReq      <= isSleep;
            if (isWdt)
            begin
                time_out_flag   <= 1'b1;
                power_down_flag <= 1'b1;
            end
            else if (isSleep)
            begin
                time_out_flag   <= 1'b1;
                power_down_flag <= 1'b0;
            end
        end
    end

endmodule // mcu_instruction_decode_execute

/* tb/file_table_model.sv */
// Model of the file registers and table memory beside the decode block.
// Assumes a write strobe names the address presented one cycle earlier.
`timescale 1ns/100ps
module file_table_model (
    input  wire logic        core_clk,   // Clock
    input  wire logic [8:0]  fileAddr,   // Read address
    output logic      [7:0]  fileRdData, // Read data
    input  wire logic        fileWrEn,   // Write strobe
    input  wire logic [7:0]  fileWrData, // Write data
    input  wire logic [11:0] tableAddr,  // Table address
    output logic      [15:0] tableWord   // Table word
);
    logic [7:0] mem [512];
    logic [8:0] wrAddr_q;
    initial
        for (int i = 0; i < 512; i++)
            mem[i] = 8'h00;
    assign fileRdData = mem[fileAddr];
    // One stored word, other addresses vary
    assign tableWord = tableAddr == 12'h234 ? 16'h3789 : {tableAddr, 4'hA};
    always @(posedge core_clk)
    begin
        wrAddr_q <= fileAddr;
        if (fileWrEn)
            mem[wrAddr_q] <= fileWrData;
    end
endmodule // file_table_model

/* tb/mcu_decode_assertions.sv */
// Checker on the decode block's ports: results one edge after execution.
// Assumes one clock, core_clk, and synchronous high reset.
`timescale 1ns/100ps
module mcu_decode_checker (
    input wire logic        core_clk,       // Clock
    input wire logic        reset,          // Reset
    input wire logic [15:0] instrWord,      // Word
    input wire logic [12:0] progAddr,       // PC
    input wire logic [11:0] tableAddr,      // Table address
    input wire logic [7:0]  tablePtrLow,    // Pointer low
    input wire logic [3:0]  tablePtrHigh,   // Pointer high
    input wire logic [7:0]  fileRdData,     // File read
    input wire logic        fileWrEn,       // Write strobe
    input wire logic [7:0]  fileWrData,     // Write data
    input wire logic [7:0]  workReg,        // Working register
    input wire logic        zeroFlag,       // Zero
    input wire logic        gieSet,         // Enable pulse
    input wire logic        watchdogClear,  // Watchdog pulse
    input wire logic        sleepReq,       // Sleep pulse
    input wire logic        time_out_flag,  // Time-out
    input wire logic        power_down_flag // Power-down
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    // Words that may take two cycles
    wire logic slowWord = instrWord[13:12] == 2'h2 || instrWord[15:8] == 8'h18
        || instrWord[13:11] == 3'h7 || instrWord[13:11] == 3'h1 && &instrWord[9:8]
        || instrWord inside {16'h0040, 16'h0050, 16'h0058, 16'h0060};
    wire logic [12:0] target  = {instrWord[15:14], instrWord[10:0]};
    wire logic [7:0]  litByte = instrWord[7:0];
    logic             slowPrev_q;
    always_ff @(posedge core_clk) slowPrev_q <= reset ? 1'b0 : slowWord;
    // Surely executed, not a dead cycle
    wire logic live = !slowPrev_q;
    ////////////////////////////////////////////////////////////
    property p_clear_work; live && instrWord == 16'h0140 |=> workReg == 8'h00 && zeroFlag; endproperty
    a_clear_work: assert property (p_clear_work) else $error("clear work wrong");
    property p_movl; live && instrWord[15:8] == 8'h19 |=> workReg == $past(litByte); endproperty
    a_movl: assert property (p_movl) else $error("literal move wrong");
    property p_xorl; live && instrWord[15:8] == 8'h1D |=> workReg == ($past(workReg)
        ^ $past(litByte)) && zeroFlag == (workReg == 8'h00); endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");
    property p_addf; live && instrWord[13:7] == 7'h0F |=> fileWrEn
        && fileWrData == 8'($past(workReg) + $past(fileRdData)); endproperty
    a_addf: assert property (p_addf) else $error("file add write wrong");
    property p_brch; live && instrWord[13:12] == 2'h2 |=> progAddr == $past(target); endproperty
    a_brch: assert property (p_brch) else $error("branch target wrong");
    property p_dead; live && instrWord[13:12] == 2'h2 |=> ##1 !fileWrEn && $stable(workReg);
    endproperty
    a_dead: assert property (p_dead) else $error("dead cycle acted");
    property p_slp; live && instrWord == 16'h1E03 |=> sleepReq && time_out_flag
        && !power_down_flag; endproperty
    a_slp: assert property (p_slp) else $error("sleep wrong");
    property p_wdt; live && instrWord == 16'h1E04 |=> watchdogClear && time_out_flag
        && power_down_flag; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    property p_return_interrupt; live && instrWord == 16'h0060 |=> gieSet ##1 !gieSet; endproperty
    a_return_interrupt: assert property (p_return_interrupt) else $error("interrupt return wrong");
    property p_tptr; tableAddr == {tablePtrHigh, tablePtrLow}; endproperty
    a_tptr: assert property (p_tptr) else $error("table address wrong");
    c_call: cover property (live && instrWord[13:12] == 2'h2);
    c_skip: cover property (live && instrWord[13:11] == 3'h7);
    c_file: cover property (fileWrEn);
endmodule // mcu_decode_checker
bind mcu_instruction_decode_execute mcu_decode_checker u_check (.*);

/* tb/tb_top.sv */
// Bench for the decode block: an instruction stream with expected results.
// Assumes the file model answers reads at once and lands writes a cycle late.
`timescale 1ns/100ps
`include "mcu_core_params.svh"
module tb_top;
    logic                core_clk     = 1'b0;
    logic                reset        = 1'b1;
    logic [`INSTR_W-1:0] instrWord    = 16'h0000;
    logic [7:0]          tablePtrLow  = 8'h00;
    logic [3:0]          tablePtrHigh = 4'h0;
    logic [`PC_W-1:0]    progAddr, pcAt, pcRet;
    logic [`TPTR_W-1:0]  tableAddr;
    logic [15:0]         tableWord;
    logic [`FADDR_W-1:0] fileAddr;
    logic [7:0]          fileRdData, fileWrData, workReg;
    logic                fileWrEn, carryFlag, digit_carry_flag, zeroFlag;
    logic                gieSet, watchdogClear, sleepReq, time_out_flag, power_down_flag;
    int                  fails    = 0;
    int                  compares = 0;
    mcu_instruction_decode_execute dut (.*);
    file_table_model fm (.core_clk(core_clk), .fileAddr(fileAddr), .fileRdData(fileRdData),
        .fileWrEn(fileWrEn), .fileWrData(fileWrData), .tableAddr(tableAddr),
        .tableWord(tableWord));
    initial
        forever #12.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Present w, then nxt, and compare once w has executed
    task automatic step(input logic [15:0] w, input logic [15:0] nxt, input logic [7:0] expW,
                        input logic [2:0] expF, input logic [8:0] expWr);
        @(posedge core_clk) instrWord <= w;
        @(negedge core_clk) pcAt = progAddr;
        @(posedge core_clk) instrWord <= nxt;
        @(negedge core_clk);
        chk(workReg, expW);
        chk({carryFlag, digit_carry_flag, zeroFlag}, expF);
        chk({fileWrEn, fileWrData & {8{fileWrEn}}}, expWr);
    endtask
    task automatic conclude;
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        fm.mem[9'h042] = 8'hC2;
        fm.mem[9'h043] = 8'h17;
        fm.mem[9'h066] = 8'hE6;
        fm.mem[9'h000] = 8'hFF;
        reset        <= 1'b0;
        tablePtrHigh <= 4'h2;
        tablePtrLow  <= 8'h34;
        step(16'h1917, 16'h0, 8'h17, 3'h0, 9'h0);
        step(16'h07C2, 16'h0, 8'h17, 3'h0, 9'h1D9);
        step(16'h0243, 16'h0, 8'h00, 3'h7, 9'h0);
        step(16'h1902, 16'h0, 8'h02, 3'h7, 9'h0);
        step(16'h1F01, 16'h0, 8'hFF, 3'h0, 9'h0);
        step(16'h1CFF, 16'h0, 8'hFE, 3'h6, 9'h0);
        step(16'h0140, 16'h0, 8'h00, 3'h7, 9'h0);
        step(16'h1DFE, 16'h0, 8'hFE, 3'h6, 9'h0);
        step(16'h0C66, 16'h0, 8'hF3, 3'h2, 9'h0);
        step(16'h0D66, 16'h0, 8'hCC, 3'h6, 9'h0);
        step(16'h0F80, 16'h1933, 8'hCC, 3'h6, 9'h100);
        step(16'h0, 16'h0, 8'hCC, 3'h6, 9'h0);
        step(16'h3F80, 16'h1933, 8'hCC, 3'h6, 9'h0);
        step(16'h3B80, 16'h1944, 8'h33, 3'h6, 9'h0);
        step(16'h0, 16'h0, 8'h33, 3'h6, 9'h0);
        step(16'h3780, 16'h0, 8'h33, 3'h6, 9'h180);
        step(16'h1E07, 16'h0, 8'h33, 3'h6, 9'h0);
        step(16'hA234, 16'h1966, 8'h33, 3'h6, 9'h0);
        pcRet = pcAt + 13'h0001;
        chk(progAddr, 16'h1234);
        step(16'h0, 16'h0, 8'h33, 3'h6, 9'h0);
        step(16'h1855, 16'h1966, 8'h55, 3'h6, 9'h0);
        chk(progAddr, pcRet);
        step(16'h0, 16'h0, 8'h55, 3'h6, 9'h0);
        step(16'h6ABC, 16'h0, 8'h55, 3'h6, 9'h0);
        chk(progAddr, 16'h0ABC);
        step(16'h0050, 16'h0, 8'h89, 3'h6, 9'h0);
        step(16'h0058, 16'h0, 8'h37, 3'h6, 9'h0);
        step(16'h1E03, 16'h0, 8'h37, 3'h6, 9'h0);
        chk({sleepReq, time_out_flag, power_down_flag}, 16'h6);
        step(16'h1E04, 16'h0, 8'h37, 3'h6, 9'h0);
        chk({watchdogClear, time_out_flag, power_down_flag}, 16'h7);
        step(16'h0566, 16'h0, 8'h26, 3'h6, 9'h0);
        step(16'h0EE6, 16'h0, 8'h26, 3'h6, 9'h16E);
        step(16'h0900, 16'h0, 8'h7F, 3'h6, 9'h0);
        step(16'h01C3, 16'h0, 8'h7F, 3'h7, 9'h100);
        step(16'h0843, 16'h0, 8'h00, 3'h7, 9'h0);
        step(16'h3380, 16'h0, 8'h00, 3'h7, 9'h100);
        step(16'h0060, 16'h0, 8'h00, 3'h7, 9'h0);
        chk(gieSet, 16'h1);
        conclude();
    end
endmodule // tb_top
